// file: hpa_pkg.sv
// Package with the constants and types of the host port access handshake.
package hpa_pkg;

   localparam int unsigned CLK_PERIOD_NS   = 5;
   localparam int unsigned ADDR_W          = 3;
   localparam int unsigned DATA_W          = 8;
   localparam int unsigned SYNC_STAGES     = 2;

   // Latency budgets in device clock periods, counted from the strobe edge.
   localparam int unsigned SPLIT_FAST_MAX  = 3;
   localparam int unsigned SPLIT_MED_MAX   = 4;
   localparam int unsigned SPLIT_SLOW_MAX  = 5;
   localparam int unsigned DSTB_FAST_MAX   = 4;
   localparam int unsigned DSTB_MED_MAX    = 5;
   localparam int unsigned DSTB_SLOW_MAX   = 6;

   // Two periods go to the input synchroniser and one to the answer flop.
   localparam int unsigned PIPE_CYCLES     = 3;
   localparam logic [2:0]  WAIT_SPLIT_FAST = 3'h0;
   localparam logic [2:0]  WAIT_SPLIT_MED  = 3'h1;
   localparam logic [2:0]  WAIT_SPLIT_SLOW = 3'h2;
   localparam logic [2:0]  WAIT_DSTB_FAST  = 3'h1;
   localparam logic [2:0]  WAIT_DSTB_MED   = 3'h2;
   localparam logic [2:0]  WAIT_DSTB_SLOW  = 3'h3;

   localparam logic [2:0]  ADDR_MULTI      = 3'h0;
   localparam logic [2:0]  ADDR_MED        = 3'h4;
   localparam logic [2:0]  ADDR_DSTB_MED   = 3'h5;

   typedef struct packed {
      logic              chip_sel_n;
      logic              data_strobe_n;
      logic              rw_wr;
      logic [2:0]        addr;
      logic              ram_access;
   } hpa_bus_t;

   typedef enum logic [1:0] {
      HPA_SPEED_FAST,
      HPA_SPEED_MED,
      HPA_SPEED_SLOW
   } hpa_speed_t;

endpackage : hpa_pkg

// file: hpa_port.sv
// Access handshake of the 8-bit parallel host port, both bus styles.
`timescale 1ns/1ps
// Contract
// - With the style pin high the port uses data strobe plus read/write line and an active-low acknowledge.
// - With the style pin low the port uses separate read and write strobes and a ready output.
// - Split-strobe latency runs from the falling strobe edge to the rising edge of ready and depends on the address.
// - Split-strobe accesses to addresses 7, 6, 5, 3, 2 and 1 raise ready within three clock periods.
// - Split-strobe accesses to address 4 and control accesses at address 0 raise ready within four periods.
// - Split-strobe coefficient RAM accesses at address 0 raise ready within five periods.
// - Data-strobe latency runs from the falling data strobe edge to the falling acknowledge edge.
// - Data-strobe accesses to addresses 7, 6, 3, 2 and 1 assert acknowledge within four periods.
// - Data-strobe accesses to addresses 4 and 5 and control accesses at address 0 acknowledge within five periods.
// - Data-strobe coefficient RAM accesses at address 0 acknowledge within six periods.
// - In data-strobe style a completed write is signalled by pulling the acknowledge low.
// - The acknowledge or ready pin is open drain and only ever pulls low.
module hpa_port (
   input  wire logic              clk_i,
   input  wire logic              reset_i,
   input  wire logic              style_sel_i,
   input  wire logic              chip_sel_n_i,
   input  wire logic              data_strobe_n_i,
   input  wire logic              rw_wr_i,
   input  wire logic [2:0]        addr_i,
   input  wire logic              ram_access_i,
   output logic                   transfer_ack_n_o,
   output logic                   transfer_ack_oe_o,
   output logic                   access_start_o,
   output logic                   access_write_o,
   output logic [2:0]             access_addr_o
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT,
      ST_ANSWER
   } hpa_state_t;

   hpa_pkg::hpa_bus_t  bus_in;
   hpa_pkg::hpa_bus_t  meta_ff;
   hpa_pkg::hpa_bus_t  sync_ff;
   logic               style_meta_ff;
   logic               style_ff;
   hpa_state_t         state_ff;
   hpa_state_t         nxt_state;
   logic [2:0]         wait_ff;
   logic [2:0]         nxt_wait;
   logic               pull_ff;
   logic               nxt_pull;
   logic               start_ff;
   logic               nxt_start;
   logic               write_ff;
   logic               nxt_write;
   logic [2:0]         addr_ff;
   logic [2:0]         nxt_addr;
   logic               strobe_on;
   logic               is_write;
   logic [2:0]         take_wait;

   assign bus_in = '{chip_sel_n: chip_sel_n_i, data_strobe_n: data_strobe_n_i,
                     rw_wr: rw_wr_i, addr: addr_i, ram_access: ram_access_i};

   // Every pin passes two flops; the first stage is read by nothing else.
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_ff       <= '{chip_sel_n: 1'b1, data_strobe_n: 1'b1, rw_wr: 1'b1,
                            addr: 3'h0, ram_access: 1'b0};
         sync_ff       <= '{chip_sel_n: 1'b1, data_strobe_n: 1'b1, rw_wr: 1'b1,
                            addr: 3'h0, ram_access: 1'b0};
         style_meta_ff <= 1'b0;
         style_ff      <= 1'b0;
      end else begin
         meta_ff       <= bus_in;
         sync_ff       <= meta_ff;
         style_meta_ff <= style_sel_i;
         style_ff      <= style_meta_ff;
      end
   end

   function automatic hpa_pkg::hpa_speed_t speed_of(input logic       dstb,
                                                    input logic [2:0] addr,
                                                    input logic       ram);
      if (addr == hpa_pkg::ADDR_MULTI) begin
         speed_of = ram ? hpa_pkg::HPA_SPEED_SLOW : hpa_pkg::HPA_SPEED_MED;
      end else if (addr == hpa_pkg::ADDR_MED) begin
         speed_of = hpa_pkg::HPA_SPEED_MED;
      end else if (dstb && addr == hpa_pkg::ADDR_DSTB_MED) begin
         speed_of = hpa_pkg::HPA_SPEED_MED;
      end else begin
         speed_of = hpa_pkg::HPA_SPEED_FAST;
      end
   endfunction : speed_of

   // Wait cycles spent in ST_WAIT, so that pipeline plus wait meets each budget.
   function automatic logic [2:0] wait_of(input logic dstb, input hpa_pkg::hpa_speed_t sp);
      unique case (sp)
         hpa_pkg::HPA_SPEED_FAST: wait_of = dstb ? hpa_pkg::WAIT_DSTB_FAST
                                                 : hpa_pkg::WAIT_SPLIT_FAST;
         hpa_pkg::HPA_SPEED_MED:  wait_of = dstb ? hpa_pkg::WAIT_DSTB_MED
                                                 : hpa_pkg::WAIT_SPLIT_MED;
         hpa_pkg::HPA_SPEED_SLOW: wait_of = dstb ? hpa_pkg::WAIT_DSTB_SLOW
                                                 : hpa_pkg::WAIT_SPLIT_SLOW;
         default:                 wait_of = hpa_pkg::WAIT_DSTB_SLOW;
      endcase
   endfunction : wait_of

   // Split style strobes are the read line and the write line, both active low;
   // data-strobe style uses one strobe and a level read/write line.
   always_comb begin
      take_wait = wait_of(style_ff, speed_of(style_ff, sync_ff.addr, sync_ff.ram_access));
      if (style_ff) begin
         strobe_on = !sync_ff.data_strobe_n;
         is_write  = !sync_ff.rw_wr;
      end else begin
         strobe_on = !sync_ff.data_strobe_n || !sync_ff.rw_wr;
         is_write  = !sync_ff.rw_wr;
      end
      strobe_on = strobe_on && !sync_ff.chip_sel_n;
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_wait  = wait_ff;
      nxt_pull  = pull_ff;
      nxt_start = 1'b0;
      nxt_write = write_ff;
      nxt_addr  = addr_ff;
      unique case (state_ff)
         ST_IDLE: begin
            // Split style holds ready low while idle so its rising edge marks completion.
            nxt_pull = !style_ff;
            if (strobe_on) begin
               nxt_start = 1'b1;
               nxt_write = is_write;
               nxt_addr  = sync_ff.addr;
               // The synchroniser already eats the budget of the split-strobe fastest class, so it answers here.
               if (take_wait == 3'h0) begin
                  nxt_state = ST_ANSWER;
                  nxt_pull  = style_ff;
               end else begin
                  nxt_state = ST_WAIT;
                  nxt_wait  = take_wait - 3'h1;
                  nxt_pull  = !style_ff;
               end
            end
         end
         ST_WAIT: begin
            if (!strobe_on) begin
               nxt_state = ST_IDLE;
               nxt_pull  = !style_ff;
            end else if (wait_ff == 3'h0) begin
               nxt_state = ST_ANSWER;
               // Data-strobe style pulls low to complete; split style releases to high.
               nxt_pull  = style_ff;
            end else begin
               nxt_wait  = wait_ff - 3'h1;
            end
         end
         ST_ANSWER: begin
            if (!strobe_on) begin
               nxt_state = ST_IDLE;
               nxt_pull  = !style_ff;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
            nxt_pull  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_ff <= ST_IDLE;
         wait_ff  <= 3'h0;
         pull_ff  <= 1'b0;
         start_ff <= 1'b0;
         write_ff <= 1'b0;
         addr_ff  <= 3'h0;
      end else begin
         state_ff <= nxt_state;
         wait_ff  <= nxt_wait;
         pull_ff  <= nxt_pull;
         start_ff <= nxt_start;
         write_ff <= nxt_write;
         addr_ff  <= nxt_addr;
      end
   end

   // The pin only ever sinks current; the high level comes from the board pull-up.
   assign transfer_ack_n_o  = 1'b0;
   assign transfer_ack_oe_o = pull_ff;
   assign access_start_o    = start_ff;
   assign access_write_o    = write_ff;
   assign access_addr_o     = addr_ff;

   sequence strobe_taken_s;
      state_ff == ST_IDLE && strobe_on;
   endsequence

   sequence strobe_held_s(int n);
      strobe_on [*1] ##0 (state_ff != ST_IDLE);
   endsequence

   split_fast_lat_a: assert property (@(posedge clk_i) disable iff (reset_i)
      strobe_taken_s ##0 (!style_ff && take_wait == hpa_pkg::WAIT_SPLIT_FAST) |=> !pull_ff)
      else $error("split fast access not ready in time");

   split_med_lat_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_ff == ST_IDLE && strobe_on && !style_ff && take_wait == hpa_pkg::WAIT_SPLIT_MED)
      ##1 strobe_on [*1] |=> !pull_ff)
      else $error("split medium access not ready in time");

   split_slow_lat_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_ff == ST_IDLE && strobe_on && !style_ff && take_wait == hpa_pkg::WAIT_SPLIT_SLOW)
      ##1 strobe_on [*2] |=> !pull_ff)
      else $error("split slow access not ready in time");

   dstb_fast_lat_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_ff == ST_IDLE && strobe_on && style_ff && take_wait == hpa_pkg::WAIT_DSTB_FAST)
      ##1 strobe_on [*1] |=> pull_ff)
      else $error("data strobe fast access not acknowledged in time");

   dstb_med_lat_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_ff == ST_IDLE && strobe_on && style_ff && take_wait == hpa_pkg::WAIT_DSTB_MED)
      ##1 strobe_on [*2] |=> pull_ff)
      else $error("data strobe medium access not acknowledged in time");

   dstb_slow_lat_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_ff == ST_IDLE && strobe_on && style_ff && take_wait == hpa_pkg::WAIT_DSTB_SLOW)
      ##1 strobe_on [*3] |=> pull_ff)
      else $error("data strobe slow access not acknowledged in time");

   dstb_med_sel_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_ff == ST_IDLE && strobe_on && style_ff
       && sync_ff.addr == hpa_pkg::ADDR_DSTB_MED) |-> take_wait == hpa_pkg::WAIT_DSTB_MED)
      else $error("address five not given the medium wait");

   wait_step_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_ff == ST_WAIT && strobe_on && wait_ff != 3'h0)
      |=> (state_ff == ST_WAIT && wait_ff == $past(wait_ff) - 3'h1))
      else $error("wait count did not step down");

   wait_abort_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_ff == ST_WAIT && !strobe_on) |=> (state_ff == ST_IDLE && pull_ff == !style_ff))
      else $error("aborted access did not return to idle");

   answer_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_ff == ST_ANSWER && strobe_on) |=> (state_ff == ST_ANSWER && pull_ff == style_ff))
      else $error("answer dropped while the strobe was held");

   split_idle_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_ff == ST_IDLE && !style_ff && !strobe_on) |=> pull_ff)
      else $error("split style ready not held low while idle");

   dstb_idle_free_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_ff == ST_IDLE && style_ff && !strobe_on) |=> !pull_ff)
      else $error("data strobe acknowledge not released while idle");

   start_take_a: assert property (@(posedge clk_i) disable iff (reset_i)
      strobe_taken_s |=> (access_start_o && access_addr_o == $past(sync_ff.addr)))
      else $error("accepted access not reported");

   start_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i)
      access_start_o |=> !access_start_o)
      else $error("start pulse longer than one cycle");

   ack_release_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_ff == ST_ANSWER && !strobe_on) |=> (state_ff == ST_IDLE && pull_ff == !style_ff))
      else $error("answer not released after the strobe went away");

   no_early_ack_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (style_ff && state_ff == ST_WAIT && $past(state_ff) == ST_IDLE) |-> !pull_ff)
      else $error("acknowledge pulled low before the wait");

   drain_only_a: assert property (@(posedge clk_i) disable iff (reset_i)
      transfer_ack_oe_o |-> !transfer_ack_n_o)
      else $error("open drain pin driven high");

   cs_qualify_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_ff == ST_IDLE && sync_ff.chip_sel_n) |=> state_ff == ST_IDLE)
      else $error("access taken without chip select");

endmodule : hpa_port

// file: hpa_master_model.sv
// Behavioural processor-side bus master for the host port.
`timescale 1ns/1ps
module hpa_master_model (
   input  wire logic       clk_i,
   input  wire logic       ack_pin_i,
   output logic            chip_sel_n_o,
   output logic            data_strobe_n_o,
   output logic            rw_wr_o,
   output logic [2:0]      addr_o,
   output logic            ram_access_o
);
   initial begin
      chip_sel_n_o    = 1'h1;
      data_strobe_n_o = 1'h1;
      rw_wr_o         = 1'h1;
      addr_o          = 3'h0;
      ram_access_o    = 1'h0;
   end

   // One access; lat is the edge of the answer, 0 if none came within lim edges.
   // A small lim removes the strobe early, which is how an abort is commanded.
   task automatic access(input logic st, input logic [2:0] a, input logic ram,
                         input logic wr, input logic cs, input int lim,
                         output int lat, output int rel);
      @(posedge clk_i);
      chip_sel_n_o <= ~cs;
      addr_o       <= a;
      ram_access_o <= ram;
      if (st) begin
         data_strobe_n_o <= 1'h0;
         rw_wr_o         <= ~wr;
      end else if (wr) begin
         rw_wr_o <= 1'h0;
      end else begin
         data_strobe_n_o <= 1'h0;
      end
      lat = 0;
      rel = 0;
      for (int i = 1; i <= lim && lat == 0; i++) begin
         @(posedge clk_i);
         #1;
         if (ack_pin_i === ~st) lat = i;
      end
      @(posedge clk_i);
      chip_sel_n_o    <= 1'h1;
      data_strobe_n_o <= 1'h1;
      rw_wr_o         <= 1'h1;
      // Released address and RAM lines show the inverse, so a stale value never passes for a held one.
      addr_o          <= ~a;
      ram_access_o    <= ~ram;
      for (int i = 1; i <= 8 && rel == 0; i++) begin
         @(posedge clk_i);
         #1;
         if (ack_pin_i === st) rel = i;
      end
   endtask : access
endmodule : hpa_master_model

// file: hpa_port_tb.sv
// Self-checking testbench of the host port access handshake.
`timescale 1ns/1ps
module hpa_port_tb;
   // Row layout: style, address, RAM select, latency ceiling in clock periods.
   typedef struct packed {
      logic       st;
      logic [2:0] a;
      logic       ram;
      logic [2:0] lim;
   } hpa_row_t;
   hpa_row_t rows [18] = '{8'h73, 8'h63, 8'h53, 8'h33, 8'h23, 8'h13, 8'h44, 8'h04, 8'h0d,
                           8'hf4, 8'he4, 8'hb4, 8'ha4, 8'h94, 8'hc5, 8'hd5, 8'h85, 8'h8e};
   logic       clk_i = 1'h0;
   logic       reset_i = 1'h1;
   logic       style_sel_i = 1'h0;
   logic       cs_n, dstb_n, rw_wr, ram, ack_n, ack_oe, start, wr_o;
   logic [2:0] addr, addr_o;
   wire        ack_pin = ack_oe ? ack_n : 1'h1;
   int         n_errors = 0;
   int         checks_done = 0;
   int         n_starts = 0;
   int         cycles = 0;
   int         lat, rel, s0;

   hpa_port u_dut (.clk_i(clk_i), .reset_i(reset_i), .style_sel_i(style_sel_i),
      .chip_sel_n_i(cs_n), .data_strobe_n_i(dstb_n), .rw_wr_i(rw_wr), .addr_i(addr),
      .ram_access_i(ram), .transfer_ack_n_o(ack_n), .transfer_ack_oe_o(ack_oe),
      .access_start_o(start), .access_write_o(wr_o), .access_addr_o(addr_o));
   hpa_master_model u_mst (.clk_i(clk_i), .ack_pin_i(ack_pin), .chip_sel_n_o(cs_n),
      .data_strobe_n_o(dstb_n), .rw_wr_o(rw_wr), .addr_o(addr), .ram_access_o(ram));

   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic chk_eq(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_eq

   task automatic chk_le(input int got, input int lim);
      checks_done++;
      if (got < 1 || got > lim) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h max=%h", $time, got, lim);
      end
   endtask : chk_le

   task automatic end_of_test;
      if (n_errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_of_test

   // The ceiling is several times what all accesses need, so only a hang reaches it.
   always @(posedge clk_i) begin
      cycles++;
      if (start === 1'h1) n_starts++;
      if (ack_oe === 1'h1) chk_eq({7'h0, ack_n}, 8'h0);
      if (cycles == 3000) begin
         n_errors++;
         end_of_test();
      end
   end

   task automatic run(input hpa_row_t r, input logic wr);
      s0 = n_starts;
      chk_eq({7'h0, ack_pin}, {7'h0, r.st});
      u_mst.access(r.st, r.a, r.ram, wr, 1'h1, 10, lat, rel);
      chk_le(lat, r.lim);
      chk_eq({5'h0, addr_o}, {5'h0, r.a});
      chk_eq({7'h0, wr_o}, {7'h0, wr});
      chk_eq(8'(n_starts - s0), 8'h1);
      chk_le(rel, 4);
   endtask : run

   initial begin
      repeat (20) @(posedge clk_i);
      #1;
      chk_eq({2'h0, ack_oe, start, wr_o, addr_o}, 8'h0);
      @(posedge clk_i);
      reset_i <= 1'h0;
      repeat (4) @(posedge clk_i);
      #1;
      for (int i = 0; i < 18; i++) begin
         if (style_sel_i !== rows[i].st) begin
            @(posedge clk_i);
            style_sel_i <= rows[i].st;
            repeat (5) @(posedge clk_i);
            #1;
         end
         run(rows[i], 1'h0);
         run(rows[i], 1'h1);
      end
      s0 = n_starts;
      u_mst.access(1'h1, 3'h2, 1'h0, 1'h1, 1'h0, 8, lat, rel);
      chk_eq(8'(lat), 8'h0);
      chk_eq(8'(n_starts - s0), 8'h0);
      // A slow access whose strobe leaves before the answer must fall back to idle.
      u_mst.access(1'h1, 3'h0, 1'h1, 1'h0, 1'h1, 1, lat, rel);
      chk_eq(8'(lat), 8'h0);
      repeat (8) @(posedge clk_i);
      #1;
      run(rows[17], 1'h1);
      end_of_test();
   end
endmodule : hpa_port_tb
